// File: pkg/slice_if.sv
/*
 * Carrier between the top and the operand resolver: slice pointers in,
 * resolved address and validity out.
 * Assumes a single clock domain; purely combinational traffic.
 */
`timescale 1ns/10ps
`default_nettype none

interface slice_if;
	logic [7:0] low_ptr;    // Low slice pointer value
	logic [7:0] high_ptr;   // High slice pointer value
	logic [7:0] operand;    // Raw operand field
	logic       short_form; // Operand is a 4-bit field
	logic [7:0] addr;       // Resolved register address
	logic       is_wreg;    // Operand resolved through a pointer
	logic       illegal;    // Direct name of a common-area byte

	modport top (output low_ptr, high_ptr, operand, short_form, input addr, is_wreg, illegal);
	modport res (input low_ptr, high_ptr, operand, short_form, output addr, is_wreg, illegal);
endinterface

`default_nettype wire

// File: pkg/wreg_pkg.sv
/*
 * Types for the working-register address generator.
 * Assumes wreg_regs.svh supplies the numeric constants.
 */
package wreg_pkg;

	// One-hot stack sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PUSH = 4'h2,
		ST_POP  = 4'h4,
		ST_WAIT = 4'h8
	} stack_state_t;

	// Stack operation requested by the execute unit
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_CALL = 3'h1,
		OP_RET  = 3'h2,
		OP_INTR = 3'h3,
		OP_INTERRUPT_RETURN_INSTR = 3'h4,
		OP_PUSH = 3'h5,
		OP_POP  = 3'h6
	} stack_op_t;

	// Pointer load selects
	typedef enum logic [1:0] {
		PTR_NONE = 2'h0,
		PTR_BOTH = 2'h1,
		PTR_LOW  = 2'h2,
		PTR_HIGH = 2'h3
	} ptr_load_t;

endpackage

// File: pkg/wreg_regs.svh
/*
 * Constants for the working-register address generator: control-register
 * addresses, reset values of the slice pointers and field positions.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef WREG_REGS_SVH
`define WREG_REGS_SVH

// ****************************************
// Control area addresses
// ****************************************
`define ADDR_LOW_SLICE_PTR   8'hd6
`define ADDR_HIGH_SLICE_PTR  8'hd7
`define ADDR_STACK_PTR_HIGH  8'hd8
`define ADDR_STACK_PTR_LOW   8'hd9

// ****************************************
// Reset values and fields
// ****************************************
`define LOW_SLICE_PTR_RESET  8'hc0
`define HIGH_SLICE_PTR_RESET 8'hc8
`define SLICE_STEP           8'h08
`define WREG_NIBBLE_TAG      4'hc
`define UPPER_AREA_BASE      8'hc0
`define COMMON_AREA_TOP      8'hcf

`endif

// File: tb/regfile_model.sv
/*
 * Register-file model on the far side of the stack byte port.
 * Assumes reads are taken in the cycle of the read strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module regfile_model (
	input  wire logic       clock,       // Core clock
	input  wire logic       mem_wr,      // Write strobe
	input  wire logic       mem_rd,      // Read strobe
	input  wire logic [7:0] mem_addr,    // Byte address
	input  wire logic [7:0] mem_wr_data, // Write byte
	output logic      [7:0] mem_rd_data  // Read byte
);
	logic [7:0] mem_q [256];
	always_ff @(posedge clock) begin
		if (mem_wr)
			mem_q[mem_addr] <= mem_wr_data;
	end
	// Byte stands while the strobe is high; inverted otherwise so a mistimed read fails
	assign mem_rd_data = mem_rd ? mem_q[mem_addr] : ~mem_q[mem_addr];
endmodule // regfile_model
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Self-checking bench: pointers, operand resolution and stack traffic.
 * Assumes the register-file model stands on the stack port.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clock, sys_rst, short_form, pair_access, reg_wr, addr_bad;
	logic [7:0] operand, ptr_value, reg_wr_addr, reg_wr_data, flags_in, push_data, mem_rd_data;
	logic [7:0] addr_hi, addr_lo, low_ptr, high_ptr, mem_addr, mem_wr_data, flags_out, pop_data;
	logic mem_wr, mem_rd, pc_load, flags_load, op_done;
	logic [15:0] pc_in, sp, pc_out, e_sp, q_wr[$], q_pc[$], q_fl[$];
	logic [7:0] e_lo, e_hi, rnd;
	wreg_pkg::ptr_load_t ptr_load;
	wreg_pkg::stack_op_t stack_op;
	int bad_count, checked, cyc;
	working_register_address_gen dut (.clock(clock), .sys_rst(sys_rst), .operand(operand),
		.short_form(short_form), .pair_access(pair_access), .ptr_load(ptr_load),
		.ptr_value(ptr_value), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data), .stack_op(stack_op), .pc_in(pc_in), .flags_in(flags_in),
		.push_data(push_data), .mem_rd_data(mem_rd_data), .addr_hi(addr_hi),
		.addr_lo(addr_lo), .addr_bad(addr_bad), .low_ptr(low_ptr), .high_ptr(high_ptr),
		.sp(sp), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data), .mem_wr(mem_wr),
		.mem_rd(mem_rd), .pc_out(pc_out), .flags_out(flags_out), .pc_load(pc_load),
		.flags_load(flags_load), .pop_data(pop_data), .op_done(op_done));
	regfile_model u_mem (.clock(clock), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	task automatic setp(input wreg_pkg::ptr_load_t k, input logic [7:0] v);
		ptr_load = k;
		ptr_value = v;
		tick;
		ptr_load = wreg_pkg::PTR_NONE;
		tick;
		if (k == wreg_pkg::PTR_BOTH || k == wreg_pkg::PTR_LOW) e_lo = v;
		if (k == wreg_pkg::PTR_HIGH) e_hi = v;
		if (k == wreg_pkg::PTR_BOTH) e_hi = v + 8'h08;
		chk({low_ptr, high_ptr}, {e_lo, e_hi});
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_wr = 1'b1;
		reg_wr_addr = a;
		reg_wr_data = d;
		tick;
		reg_wr = 1'b0;
		tick;
	endtask
	task automatic res(input logic [7:0] o, input logic s, p);
		logic [7:0] a;
		a = (s || o[7:4] == 4'hc) ? {o[3] ? e_hi[7:3] : e_lo[7:3], o[2:0]} : o;
		operand = o;
		short_form = s;
		pair_access = p;
		tick;
		chk({addr_hi, addr_lo}, {p ? a & 8'hfe : a, a | 8'h01});
		chk({15'h0000, addr_bad}, 16'h0000);
	endtask
	task automatic wrn(input logic [7:0] b);
		e_sp = e_sp - 16'h0001;
		q_wr.push_back({e_sp[7:0], b});
	endtask
	task automatic stk(input wreg_pkg::stack_op_t k, input logic [15:0] pc, input logic [7:0] fl);
		int n;
		stack_op = k;
		pc_in = pc;
		flags_in = fl;
		n = 0;
		while (op_done !== 1'b1 && n < 20) begin
			tick;
			n++;
		end
		stack_op = wreg_pkg::OP_NONE;
		if (n == 20) bad_count++;
		tick;
		chk(sp, e_sp);
	endtask
	// ****************************************
	// Result monitor and hang limit
	// ****************************************
	always @(negedge clock) begin
		if (mem_wr === 1'b1) chk({mem_addr, mem_wr_data}, q_wr.pop_front());
		if (pc_load === 1'b1) chk(pc_out, q_pc.pop_front());
		if (flags_load === 1'b1) chk({8'h00, flags_out}, q_fl.pop_front());
		cyc++;
		if (cyc > 3000) begin
			bad_count++;
			end_sim;
		end
	end
	initial begin
		{sys_rst, short_form, pair_access, reg_wr} = 4'h8;
		{operand, ptr_value, reg_wr_addr, reg_wr_data, flags_in, push_data} = '0;
		ptr_load = wreg_pkg::PTR_NONE;
		stack_op = wreg_pkg::OP_NONE;
		pc_in = 16'h0000;
		rnd = 8'h07;
		repeat (4) @(posedge clock);
		#1 sys_rst = 1'b0;
		{e_lo, e_hi} = 16'hc0c8;
		chk({low_ptr, high_ptr}, 16'hc0c8);
		res(8'h0d, 1'b1, 1'b1);
		$display("test reset done");
		setp(wreg_pkg::PTR_BOTH, 8'h70);
		setp(wreg_pkg::PTR_HIGH, 8'h48);
		setp(wreg_pkg::PTR_LOW, 8'ha0);
		wr(8'hd6, 8'h00);
		wr(8'hd7, 8'hf8);
		chk({low_ptr, high_ptr}, 16'h00f8);
		{e_lo, e_hi} = 16'h00f8;
		setp(wreg_pkg::PTR_BOTH, 8'hf8);
		setp(wreg_pkg::PTR_BOTH, 8'h70);
		setp(wreg_pkg::PTR_HIGH, 8'ha8);
		res(8'h06, 1'b1, 1'b0);
		res(8'hab, 1'b0, 1'b0);
		res(8'hf5, 1'b0, 1'b1);
		repeat (24) begin
			rnd = lfsr(rnd);
			setp(wreg_pkg::ptr_load_t'(rnd[2:1]), lfsr(rnd));
			rnd = lfsr(rnd);
			res(rnd[6] ? {4'hc, rnd[3:0]} : rnd, rnd[5], rnd[0]);
		end
		$display("test pointers done");
		wr(8'hd8, 8'h00);
		wr(8'hd9, 8'hff);
		e_sp = 16'h00ff;
		wrn(8'h34);
		wrn(8'h12);
		stk(wreg_pkg::OP_CALL, 16'h1234, 8'h00);
		wrn(8'hcd);
		wrn(8'hab);
		wrn(8'h5a);
		stk(wreg_pkg::OP_INTR, 16'habcd, 8'h5a);
		q_pc.push_back(16'habcd);
		q_fl.push_back(16'h005a);
		e_sp = e_sp + 16'h0003;
		stk(wreg_pkg::OP_INTERRUPT_RETURN_INSTR, 16'h0000, 8'h00);
		q_pc.push_back(16'h1234);
		e_sp = e_sp + 16'h0002;
		stk(wreg_pkg::OP_RET, 16'h0000, 8'h00);
		wr(8'hd8, 8'h01);
		wr(8'hd9, 8'h00);
		e_sp = 16'h0100;
		rnd = lfsr(rnd);
		push_data = rnd;
		wrn(rnd);
		stk(wreg_pkg::OP_PUSH, 16'h0000, 8'h00);
		e_sp = e_sp + 16'h0001;
		stk(wreg_pkg::OP_POP, 16'h0000, 8'h00);
		chk({8'h00, pop_data}, {8'h00, rnd});
		chk(q_wr.size() + q_pc.size() + q_fl.size(), 16'h0000);
		$display("test stack done");
		end_sim;
	end
endmodule // tb_top
`default_nettype wire

// File: tb/wrag_chk.sv
/*
 * Port-level assertions for the address generator.
 * Assumes it is bound to the top module.
 */
`timescale 1ns/10ps
`default_nettype none
module wrag_chk (
	input wire logic        clock,       // Clock
	input wire logic        sys_rst,     // Reset
	input wire logic [7:0]  operand,     // Operand
	input wire logic        short_form,  // Short form
	input wire logic        pair_access, // Pair
	input wire logic [1:0]  ptr_load,    // Pointer load
	input wire logic [7:0]  ptr_value,   // Pointer value
	input wire logic [7:0]  addr_hi,     // Address
	input wire logic [7:0]  addr_lo,     // Pair LSB
	input wire logic [7:0]  low_ptr,     // Low pointer
	input wire logic [7:0]  high_ptr,    // High pointer
	input wire logic [15:0] sp,          // Stack pointer
	input wire logic [7:0]  mem_addr,    // Stack address
	input wire logic        mem_wr,      // Write strobe
	input wire logic        mem_rd       // Read strobe
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	chk_reset_ptrs: assert property ($past(sys_rst) |-> low_ptr == 8'hc0 && high_ptr == 8'hc8)
		else $error("pointers wrong after reset");
	chk_short_form: assert property (short_form && !pair_access |=> addr_hi ==
		{$past(operand[3]) ? $past(high_ptr[7:3]) : $past(low_ptr[7:3]), $past(operand[2:0])})
		else $error("short form address wrong");
	chk_long_form: assert property (!short_form && operand[7:4] == 4'hc && !pair_access |=>
		addr_hi == {$past(operand[3]) ? $past(high_ptr[7:3]) : $past(low_ptr[7:3]), $past(operand[2:0])})
		else $error("long form address wrong");
	chk_direct_name: assert property (!short_form && operand[7:4] != 4'hc |=>
		addr_hi[7:1] == $past(operand[7:1])) else $error("direct address wrong");
	chk_pair_order: assert property (pair_access |=> !addr_hi[0] && addr_lo == (addr_hi | 8'h01))
		else $error("pair order wrong");
	chk_set_both: assert property (ptr_load == 2'h1 |=> low_ptr == $past(ptr_value) &&
		high_ptr == $past(ptr_value) + 8'h08) else $error("set both wrong");
	chk_set_low: assert property (ptr_load == 2'h2 |=> low_ptr == $past(ptr_value) && $stable(high_ptr))
		else $error("set low wrong");
	chk_push_dec: assert property (mem_wr |-> mem_addr == sp[7:0] && sp == $past(sp) - 16'h0001)
		else $error("push address wrong");
	chk_pop_inc: assert property (mem_rd |-> mem_addr == sp[7:0] - 8'h01 &&
		sp == $past(sp) + 16'h0001) else $error("pop address wrong");
endmodule // wrag_chk
bind working_register_address_gen wrag_chk u_chk (.clock, .sys_rst, .operand, .short_form,
	.pair_access, .ptr_load, .ptr_value, .addr_hi, .addr_lo, .low_ptr, .high_ptr, .sp, .mem_addr,
	.mem_wr, .mem_rd);
`default_nettype wire

// File: verilog/operand_resolver.sv
/*
 * Resolves a 4-bit or 8-bit register operand into an 8-bit register
 * address using the two slice pointers.
 * Assumes pointers are stable during the cycle in which they are read.
 */
`timescale 1ns/10ps
`default_nettype none
`include "wreg_regs.svh"

module operand_resolver (
	slice_if.res port // Pointer and operand carrier
);
	wire       is_tagged;
	wire       use_high;
	wire [7:0] chosen_ptr;
	wire [7:0] wreg_addr;

	assign is_tagged  = port.operand[7:4] == `WREG_NIBBLE_TAG;
	assign use_high   = port.operand[3];
	assign chosen_ptr = use_high ? port.high_ptr : port.low_ptr;
	// Pointer bits 2:0 are dropped here
	assign wreg_addr  = {chosen_ptr[7:3], port.operand[2:0]};

	assign port.is_wreg = port.short_form | is_tagged;
	// Plain 8-bit names pass through, reaching the upper control area above the common area
	assign port.addr    = port.is_wreg ? wreg_addr : port.operand;
	// Common-area names carry the 4'hc tag and are redirected, so this flag never rises
	assign port.illegal = ~port.is_wreg & (port.operand >= `UPPER_AREA_BASE)
		& (port.operand <= `COMMON_AREA_TOP);

endmodule // operand_resolver

`default_nettype wire

// File: verilog/working_register_address_gen.sv
/*
 * Working-register address generation and system-stack addressing for an
 * 8-bit core: slice pointers, operand resolution, register-pair order and
 * call/return/interrupt stack sequencing.
 * Assumes the decoder holds its request stable until op_done and that
 * software loads the stack pointer before any stack use.
 */
`timescale 1ns/10ps
`default_nettype none
`include "wreg_regs.svh"

module working_register_address_gen (
	input  wire logic                clock,       // Core clock
	input  wire logic                sys_rst,     // Synchronous reset, high
	input  wire logic [7:0]          operand,     // Operand field
	input  wire logic                short_form,  // Operand is 4-bit
	input  wire logic                pair_access, // Operand names a 16-bit pair
	input  wire wreg_pkg::ptr_load_t ptr_load,    // Pointer set instruction
	input  wire logic [7:0]          ptr_value,   // Immediate for pointer set
	input  wire logic                reg_wr,      // Direct register write
	input  wire logic [7:0]          reg_wr_addr, // Direct write address
	input  wire logic [7:0]          reg_wr_data, // Direct write data
	input  wire wreg_pkg::stack_op_t stack_op,    // Stack request
	input  wire logic [15:0]         pc_in,       // Program counter to save
	input  wire logic [7:0]          flags_in,    // Flags to save
	input  wire logic [7:0]          push_data,   // Byte for data push
	input  wire logic [7:0]          mem_rd_data, // Register file read data
	output logic [7:0]               addr_hi,     // Resolved address, MSB byte
	output logic [7:0]               addr_lo,     // Odd partner of a pair
	output logic                     addr_bad,    // Illegal direct common name
	output logic [7:0]               low_ptr,     // Low slice pointer
	output logic [7:0]               high_ptr,    // High slice pointer
	output logic [15:0]              sp,          // Stack pointer
	output logic [7:0]               mem_addr,    // Stack byte address
	output logic [7:0]               mem_wr_data, // Stack byte to write
	output logic                     mem_wr,      // Stack write strobe
	output logic                     mem_rd,      // Stack read strobe
	output logic [15:0]              pc_out,      // Restored program counter
	output logic [7:0]               flags_out,   // Restored flags
	output logic                     pc_load,     // pc_out valid pulse
	output logic                     flags_load,  // flags_out valid pulse
	output logic [7:0]               pop_data,    // Byte from data pop
	output logic                     op_done      // Stack request finished
);
	// ****************************************
	// Slice pointers and operand resolution
	// ****************************************
	logic [7:0] low_ptr_q;
	logic [7:0] low_ptr_d;
	logic [7:0] high_ptr_q;
	logic [7:0] high_ptr_d;
	wire        wr_low;
	wire        wr_high;
	wire  [7:0] res_addr;

	slice_if sif ();

	assign sif.low_ptr    = low_ptr_q;
	assign sif.high_ptr   = high_ptr_q;
	assign sif.operand    = operand;
	assign sif.short_form = short_form;

	operand_resolver u_res (
		.port (sif.res)
	);

	assign wr_low  = reg_wr && reg_wr_addr == `ADDR_LOW_SLICE_PTR;
	assign wr_high = reg_wr && reg_wr_addr == `ADDR_HIGH_SLICE_PTR;

	always_comb begin
		low_ptr_d  = low_ptr_q;
		high_ptr_d = high_ptr_q;
		unique case (ptr_load)
			wreg_pkg::PTR_BOTH: begin
				low_ptr_d  = ptr_value;
				high_ptr_d = ptr_value + `SLICE_STEP;
			end
			wreg_pkg::PTR_LOW:  low_ptr_d = ptr_value;
			wreg_pkg::PTR_HIGH: high_ptr_d = ptr_value;
			wreg_pkg::PTR_NONE: begin
				if (wr_low) low_ptr_d = reg_wr_data;
				if (wr_high) high_ptr_d = reg_wr_data;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			low_ptr_q  <= `LOW_SLICE_PTR_RESET;
			high_ptr_q <= `HIGH_SLICE_PTR_RESET;
		end else begin
			low_ptr_q  <= low_ptr_d;
			high_ptr_q <= high_ptr_d;
		end
	end

	// Pairs always start even; low bit forced so odd names still pair sanely
	assign res_addr = pair_access ? {sif.addr[7:1], 1'b0} : sif.addr;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_hi  <= 8'h00;
			addr_lo  <= 8'h00;
			addr_bad <= 1'b0;
		end else begin
			addr_hi  <= res_addr;
			addr_lo  <= {res_addr[7:1], 1'b1};
			addr_bad <= sif.illegal;
		end
	end

	assign low_ptr  = low_ptr_q;
	assign high_ptr = high_ptr_q;

	// ****************************************
	// Stack sequencer
	// ****************************************
	wreg_pkg::stack_state_t state_q;
	wreg_pkg::stack_state_t state_d;
	logic [15:0] sp_q;
	logic [15:0] sp_d;
	logic [1:0]  idx_q;
	logic [1:0]  idx_d;
	logic [23:0] save_q;
	logic [23:0] save_d;
	wreg_pkg::stack_op_t op_q;
	wreg_pkg::stack_op_t op_d;
	wire  [1:0]  op_len;
	wire         is_push_op;
	wire         sp_wr_low;
	wire         sp_wr_high;

	// Bytes per request: flags ride above the PC on interrupts
	assign op_len = (stack_op == wreg_pkg::OP_INTR || stack_op == wreg_pkg::OP_INTERRUPT_RETURN_INSTR) ? 2'd3 :
		(stack_op == wreg_pkg::OP_CALL || stack_op == wreg_pkg::OP_RET) ? 2'd2 : 2'd1;
	assign is_push_op = stack_op == wreg_pkg::OP_CALL || stack_op == wreg_pkg::OP_INTR
		|| stack_op == wreg_pkg::OP_PUSH;
	assign sp_wr_low  = reg_wr && reg_wr_addr == `ADDR_STACK_PTR_LOW;
	assign sp_wr_high = reg_wr && reg_wr_addr == `ADDR_STACK_PTR_HIGH;

	always_comb begin
		state_d = state_q;
		sp_d    = sp_q;
		idx_d   = idx_q;
		save_d  = save_q;
		op_d    = op_q;
		unique case (state_q)
			wreg_pkg::ST_IDLE: begin
				if (sp_wr_low) sp_d[7:0] = reg_wr_data;
				if (sp_wr_high) sp_d[15:8] = reg_wr_data;
				if (stack_op != wreg_pkg::OP_NONE) begin
					op_d   = stack_op;
					idx_d  = op_len;
					// Byte order: PC low, PC high, flags; flags land on top
					save_d = {flags_in, pc_in[15:8], pc_in[7:0]};
					if (stack_op == wreg_pkg::OP_PUSH) save_d = {16'h0000, push_data};
					state_d = is_push_op ? wreg_pkg::ST_PUSH : wreg_pkg::ST_POP;
				end
			end
			wreg_pkg::ST_PUSH: begin
				sp_d  = sp_q - 16'h0001;
				idx_d = idx_q - 2'd1;
				if (idx_q == 2'd1) state_d = wreg_pkg::ST_WAIT;
			end
			wreg_pkg::ST_POP: begin
				sp_d  = sp_q + 16'h0001;
				idx_d = idx_q - 2'd1;
				if (idx_q == 2'd1) state_d = wreg_pkg::ST_WAIT;
			end
			wreg_pkg::ST_WAIT: begin
				// Decoder still holds its request here; op_done rises as this state ends
				state_d = wreg_pkg::ST_IDLE;
				op_d    = wreg_pkg::OP_NONE;
			end
		endcase
	end

	// Push byte chosen from save word, highest index last (on top)
	wire [1:0] push_sel = (op_q == wreg_pkg::OP_INTR) ? 2'd3 - idx_q :
		(op_q == wreg_pkg::OP_CALL) ? 2'd2 - idx_q : 2'd0;
	wire [7:0] push_byte = push_sel == 2'd2 ? save_q[23:16] :
		push_sel == 2'd1 ? save_q[15:8] : save_q[7:0];
	wire [15:0] sp_pre = sp_q - 16'h0001;

	// No reset on the stack pointer; software must load it first
	always_ff @(posedge clock) begin
		sp_q <= sp_d;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= wreg_pkg::ST_IDLE;
			idx_q   <= 2'd0;
			save_q  <= 24'h000000;
			op_q    <= wreg_pkg::OP_NONE;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
			save_q  <= save_d;
			op_q    <= op_d;
		end
	end

	wire in_push = state_q == wreg_pkg::ST_PUSH;
	wire in_pop  = state_q == wreg_pkg::ST_POP;
	wire in_done = state_q == wreg_pkg::ST_WAIT;
	wire in_idle = state_q == wreg_pkg::ST_IDLE;

	// Address is pre-decremented for pushes, current SP for pops
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mem_addr    <= 8'h00;
			mem_wr_data <= 8'h00;
			mem_wr      <= 1'b0;
			mem_rd      <= 1'b0;
		end else begin
			mem_addr    <= in_push ? sp_pre[7:0] : sp_q[7:0];
			mem_wr_data <= push_byte;
			mem_wr      <= in_push;
			mem_rd      <= in_pop;
		end
	end

	// Read byte stands with mem_rd; count restarts in idle so a long pop cannot skew the next
	logic [1:0] rd_cnt_q;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_cnt_q   <= 2'd0;
			pc_out     <= 16'h0000;
			flags_out  <= 8'h00;
			pop_data   <= 8'h00;
			pc_load    <= 1'b0;
			flags_load <= 1'b0;
			op_done    <= 1'b0;
		end else begin
			pc_load    <= 1'b0;
			flags_load <= 1'b0;
			op_done    <= in_done;
			if (in_idle) rd_cnt_q <= 2'd0;
			if (mem_rd) begin
				rd_cnt_q <= rd_cnt_q + 2'd1;
				if (op_q == wreg_pkg::OP_POP) pop_data <= mem_rd_data;
				else if (op_q == wreg_pkg::OP_INTERRUPT_RETURN_INSTR && rd_cnt_q == 2'd0)
					flags_out <= mem_rd_data;
				else if (op_q == wreg_pkg::OP_INTERRUPT_RETURN_INSTR && rd_cnt_q == 2'd1 ||
					op_q == wreg_pkg::OP_RET && rd_cnt_q == 2'd0)
					pc_out[15:8] <= mem_rd_data;
				else pc_out[7:0] <= mem_rd_data;
			end
			if (in_done && (op_q == wreg_pkg::OP_RET || op_q == wreg_pkg::OP_INTERRUPT_RETURN_INSTR))
				pc_load <= 1'b1;
			if (in_done && op_q == wreg_pkg::OP_INTERRUPT_RETURN_INSTR) flags_load <= 1'b1;
		end
	end

	assign sp = sp_q;

endmodule // working_register_address_gen

`default_nettype wire
